/* cpu_operand_format_unit_tb_top.sv */
// self-checking testbench for the operand formatting unit
`timescale 1ns/1ps
module cpu_operand_format_unit_tb_top;
  logic mclk_i, rst_n_i, wr_valid_i, rd_bit_o, mem_req_i, mem_exc_stack_i, mem_sp_auto_i;
  logic [2:0] wr_size_i, wr_reg_i, rd_reg_i, rd_size_i, mem_size_i, int_level_i, int_mask_o;
  logic [31:0] wr_data_i, rd_data_o;
  logic [3:0] rd_bit_i, mem_bit_i;
  logic [15:0] mem_addr_i, mem_wdata_i, bus_addr_o, bus_wdata_o, bus_rdata_i, bus_lane_data_o;
  logic mem_bit_o, bus_req_o, bus_word_o, addr_err_o, ib_valid_i, ib_has_ext_i;
  logic [7:0] ib_byte_i, dec_addr_field_o, dec_ext_o, dec_opcode_o;
  logic dec_ea_start_o, dec_done_o, int_req_i, nmi_i, int_accept_o;
  int num_errors = 0;
  int samples_checked = 0;

  opfmt_unit u_opfmt_unit
  (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_valid_i(wr_valid_i), .wr_size_i(wr_size_i),
    .wr_reg_i(wr_reg_i), .wr_data_i(wr_data_i), .rd_reg_i(rd_reg_i), .rd_size_i(rd_size_i),
    .rd_bit_i(rd_bit_i), .rd_data_o(rd_data_o), .rd_bit_o(rd_bit_o), .mem_req_i(mem_req_i),
    .mem_size_i(mem_size_i), .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i),
    .mem_exc_stack_i(mem_exc_stack_i), .mem_sp_auto_i(mem_sp_auto_i), .mem_bit_i(mem_bit_i),
    .mem_bit_o(mem_bit_o), .bus_req_o(bus_req_o), .bus_word_o(bus_word_o),
    .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i),
    .bus_lane_data_o(bus_lane_data_o), .addr_err_o(addr_err_o), .ib_valid_i(ib_valid_i),
    .ib_byte_i(ib_byte_i), .ib_has_ext_i(ib_has_ext_i), .dec_addr_field_o(dec_addr_field_o),
    .dec_ext_o(dec_ext_o), .dec_opcode_o(dec_opcode_o), .dec_ea_start_o(dec_ea_start_o),
    .dec_done_o(dec_done_o), .int_level_i(int_level_i), .int_req_i(int_req_i),
    .nmi_i(nmi_i), .int_accept_o(int_accept_o), .int_mask_o(int_mask_o)
  );

  mem_bus_model u_mem_bus_model
  (
    .mclk_i(mclk_i), .req_i(bus_req_o), .addr_i(bus_addr_o), .rdata_o(bus_rdata_i)
  );

  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end

  task automatic final_report;
    begin
      if (num_errors == 0 && samples_checked > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      samples_checked++;
      if (got !== exp)
      begin
        num_errors++;
        $display("wrong value at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction

  // the extra idle cycle leaves the bank port free for a long's low half
  task automatic wr(input logic [2:0] sz, input logic [2:0] r, input logic [31:0] d);
    begin
      @(posedge mclk_i);
      wr_valid_i <= 1'b1;
      wr_size_i <= sz;
      wr_reg_i <= r;
      wr_data_i <= d;
      @(posedge mclk_i);
      wr_valid_i <= 1'b0;
      @(posedge mclk_i);
    end
  endtask

  task automatic rd(input logic [2:0] r, input logic [2:0] sz, input logic [3:0] b);
    begin
      @(posedge mclk_i);
      rd_reg_i <= r;
      rd_size_i <= sz;
      rd_bit_i <= b;
      repeat (2) @(posedge mclk_i);
      #1;
    end
  endtask

  task automatic mem(input logic [2:0] sz, input logic [15:0] a, input logic exc,
                     input logic sp, input logic [3:0] b);
    begin
      @(posedge mclk_i);
      mem_req_i <= 1'b1;
      mem_size_i <= sz;
      mem_addr_i <= a;
      mem_exc_stack_i <= exc;
      mem_sp_auto_i <= sp;
      mem_bit_i <= b;
      mem_wdata_i <= 16'hC3A5;
      @(posedge mclk_i);
      mem_req_i <= 1'b0;
      #1;
    end
  endtask

  task automatic mchk(input logic [2:0] sz, input logic [15:0] a, input logic exc,
                      input logic sp, input logic err, input logic w);
    begin
      mem(sz, a, exc, sp, 4'h0);
      chk(addr_err_o, err);
      chk(bus_req_o, !err);
      if (!err)
      begin
        chk(bus_word_o, w);
        chk(bus_addr_o, a);
        chk(bus_wdata_o, w ? 16'hC3A5 : (a[0] ? 16'h00A5 : 16'hA500));
      end
    end
  endtask

  task automatic t_regs;
    logic [15:0] v;
    begin
      wr(opfmt_pkg::SZ_WORD, 3'h3, 32'h0000_1234);
      rd(3'h3, opfmt_pkg::SZ_WORD, 4'h0);
      chk(rd_data_o[15:0], 16'h1234);
      wr(opfmt_pkg::SZ_BYTE, 3'h3, 32'h0000_00AB);
      rd(3'h3, opfmt_pkg::SZ_WORD, 4'h0);
      chk(rd_data_o[15:0], 16'h12AB);
      wr(opfmt_pkg::SZ_BCD, 3'h3, 32'h0000_0097);
      rd(3'h3, opfmt_pkg::SZ_BCD, 4'h0);
      chk(rd_data_o[7:0], 8'h97);
      v = 16'h1297;
      for (int i = 0; i < 16; i++)
      begin
        rd(3'h3, opfmt_pkg::SZ_BIT, i[3:0]);
        chk(rd_bit_o, v[i]);
      end
      wr(opfmt_pkg::SZ_LONG, 3'h2, 32'hDEAD_BEEF);
      rd(3'h2, opfmt_pkg::SZ_LONG, 4'h0);
      chk(rd_data_o, 32'hDEAD_BEEF);
      rd(3'h2, opfmt_pkg::SZ_WORD, 4'h0);
      chk(rd_data_o[15:0], 16'hDEAD);
      rd(3'h3, opfmt_pkg::SZ_WORD, 4'h0);
      chk(rd_data_o[15:0], 16'hBEEF);
    end
  endtask

  // the stack pointer is kept even except where an odd one is the point
  task automatic t_mem;
    begin
      mchk(opfmt_pkg::SZ_WORD, 16'h0010, 1'b0, 1'b0, 1'b0, 1'b1);
      chk(bus_lane_data_o, {pat(16'h0010), pat(16'h0011)});
      mchk(opfmt_pkg::SZ_BYTE, 16'h0011, 1'b0, 1'b0, 1'b0, 1'b0);
      chk(bus_lane_data_o[7:0], pat(16'h0011));
      mchk(opfmt_pkg::SZ_WORD, 16'h1001, 1'b0, 1'b0, 1'b1, 1'b0);
      mchk(opfmt_pkg::SZ_BYTE, 16'h00F1, 1'b1, 1'b0, 1'b1, 1'b0);
      mchk(opfmt_pkg::SZ_BYTE, 16'h00F2, 1'b1, 1'b0, 1'b0, 1'b1);
      mchk(opfmt_pkg::SZ_BYTE, 16'h0043, 1'b0, 1'b1, 1'b1, 1'b0);
      mchk(opfmt_pkg::SZ_BYTE, 16'h0044, 1'b0, 1'b1, 1'b0, 1'b1);
      mem(opfmt_pkg::SZ_BYTE, 16'h0020, 1'b0, 1'b0, 4'h6);
      chk(mem_bit_o, pat(16'h0020) >> 6);
      mem(opfmt_pkg::SZ_WORD, 16'h0030, 1'b0, 1'b0, 4'hD);
      chk(mem_bit_o, (pat(16'h0030) >> 5) & 8'h01);
    end
  endtask

  task automatic t_dec(input logic ext);
    begin
      @(posedge mclk_i);
      ib_valid_i <= 1'b1;
      ib_byte_i <= 8'h3C;
      ib_has_ext_i <= ext;
      @(posedge mclk_i);
      if (ext)
      begin
        ib_byte_i <= 8'h55;
        @(posedge mclk_i);
      end
      ib_byte_i <= 8'hA7;
      #1;
      chk(dec_ea_start_o, 1'b1);
      @(posedge mclk_i);
      ib_valid_i <= 1'b0;
      #1;
      chk(dec_done_o, 1'b1);
      chk(dec_addr_field_o, 8'h3C);
      chk(dec_opcode_o, 8'hA7);
      if (ext)
        chk(dec_ext_o, 8'h55);
    end
  endtask

  task automatic t_irq;
    begin
      chk(int_mask_o, 3'h7);
      for (int lv = 1; lv < 8; lv++)
      begin
        @(posedge mclk_i);
        int_req_i <= 1'b1;
        int_level_i <= lv[2:0];
        @(posedge mclk_i);
        int_req_i <= 1'b0;
        #1;
        chk(int_accept_o, 1'b0);
      end
      @(posedge mclk_i);
      nmi_i <= 1'b1;
      @(posedge mclk_i);
      nmi_i <= 1'b0;
      #1;
      chk(int_accept_o, 1'b1);
      chk(int_mask_o, 3'h7);
    end
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    {wr_valid_i, mem_req_i, mem_exc_stack_i, mem_sp_auto_i, ib_valid_i, ib_has_ext_i} = '0;
    {wr_size_i, wr_reg_i, rd_reg_i, rd_size_i, mem_size_i, int_level_i} = '0;
    {wr_data_i, rd_bit_i, mem_bit_i, mem_addr_i, mem_wdata_i, ib_byte_i} = '0;
    {int_req_i, nmi_i} = '0;
    repeat (20) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    rd(3'h5, opfmt_pkg::SZ_WORD, 4'h0);
    chk(rd_data_o, 32'h0000_0000);
    t_irq();
    t_regs();
    t_mem();
    t_dec(1'b1);
    t_dec(1'b0);
    final_report();
  end

  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    final_report();
  end
endmodule

/* mem_bus_model.sv */
// memory bus model answering operand reads in big-endian byte order
`timescale 1ns/1ps
module mem_bus_model
(
  // clock
  input wire logic mclk_i,
  // bus
  input wire logic req_i,
  input wire logic [15:0] addr_i,
  output logic [15:0] rdata_o
);
  logic [15:0] last = 16'h0000;
  logic [15:0] word;

  // even byte on the high lane, odd byte on the low lane
  assign word = {(addr_i[7:0] & 8'hFE) ^ 8'h5A, (addr_i[7:0] | 8'h01) ^ 8'h5A};
  // released bus shows the inverse of the last data so stale sampling is caught
  assign rdata_o = req_i ? word : ~last;

  always_ff @(posedge mclk_i)
  begin
    if (req_i)
      last <= word;
  end
endmodule

/* opfmt_if.sv */
// interface: register file access between core logic and register bank
`timescale 1ns/1ps
interface opfmt_if;
  logic [2:0] rd_a;
  logic [2:0] rd_b;
  logic [15:0] rdata_a;
  logic [15:0] rdata_b;
  logic we_hi;
  logic we_lo;
  logic [2:0] wr_idx;
  logic [15:0] wdata;

  modport core
  (
    output rd_a, rd_b, we_hi, we_lo, wr_idx, wdata,
    input rdata_a, rdata_b
  );

  modport bank
  (
    input rd_a, rd_b, we_hi, we_lo, wr_idx, wdata,
    output rdata_a, rdata_b
  );
endinterface

/* opfmt_pkg.sv */
// package: constants and types for the operand formatting unit
// Summary of operation
// - Operand sizes of 1, 8 (byte or two-digit bcd), 16 and 32 bits are handled.
// - Register bit positions run from 15 (msb) down to 0 (lsb).
// - Byte and bcd operands sit in bits 7..0, upper digit in 7..4, lower in 3..0.
// - Byte and bcd writes leave bits 15..8 of the destination unchanged.
// - A word operand fills all sixteen bits of one register.
// - A longword uses an even register for bits 31..16 and the next one for 15..0.
// - Bit operations on memory fetch a byte or word and pick the bit by number.
// - A word memory access at an odd byte address raises an address error.
// - Words in memory are big-endian: bits 15..8 at even n, bits 7..0 at n+1.
// - Exception stack saves and restores are always word accesses.
// - Pre-decrement or post-increment through the stack pointer is word sized.
// - The decoder takes the address field byte and extension before the opcode byte.
// - An interrupt is taken only above the 3-bit mask; level 8 is always taken.
package opfmt_pkg;
  localparam int unsigned NUM_REGS = 8;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [3:0] NMI_LEVEL = 4'h8;
  localparam logic [2:0] MASK_RESET = 3'h7;

  typedef enum logic [2:0]
  {
    SZ_BIT = 3'h0,
    SZ_BCD = 3'h1,
    SZ_BYTE = 3'h2,
    SZ_WORD = 3'h3,
    SZ_LONG = 3'h4
  } op_size_e;

  typedef enum logic [1:0]
  {
    DEC_ADDR = 2'h0,
    DEC_EXT = 2'h1,
    DEC_OPC = 2'h2
  } dec_state_e;
endpackage

/* opfmt_regbank.sv */
// general register bank with byte-lane write enables and registered reads
`timescale 1ns/1ps
module opfmt_regbank
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // access
  opfmt_if.bank rf
);
  logic [15:0] regs [opfmt_pkg::NUM_REGS];
  logic [15:0] next_regs [opfmt_pkg::NUM_REGS];
  logic [15:0] rdata_a;
  logic [15:0] rdata_b;

  always_comb
  begin
    for (int i = 0; i < opfmt_pkg::NUM_REGS; i++)
    begin
      next_regs[i] = regs[i];
    end
    // byte writes touch only the low lane
    if (rf.we_hi)
    begin
      next_regs[rf.wr_idx][15:8] = rf.wdata[15:8];
    end
    if (rf.we_lo)
    begin
      next_regs[rf.wr_idx][7:0] = rf.wdata[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < opfmt_pkg::NUM_REGS; i++)
      begin
        regs[i] <= opfmt_pkg::REG_RESET;
      end
      rdata_a <= opfmt_pkg::REG_RESET;
      rdata_b <= opfmt_pkg::REG_RESET;
    end
    else
    begin
      regs <= next_regs;
      rdata_a <= next_regs[rf.rd_a];
      rdata_b <= next_regs[rf.rd_b];
    end
  end

  assign rf.rdata_a = rdata_a;
  assign rf.rdata_b = rdata_b;

  chk_hi_lane_kept: assert property (@(posedge clk) disable iff (!rst_n)
    rf.we_lo && !rf.we_hi |=> regs[$past(rf.wr_idx)][15:8] == $past(regs[rf.wr_idx][15:8]))
    else $error("upper byte changed on byte write");
endmodule

/* opfmt_unit.sv */
// operand formatting, memory alignment, decode ordering and interrupt gate
`timescale 1ns/1ps
module opfmt_unit
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // register write from execution
  input wire logic wr_valid_i,
  input wire logic [2:0] wr_size_i,
  input wire logic [2:0] wr_reg_i,
  input wire logic [31:0] wr_data_i,
  // register read
  input wire logic [2:0] rd_reg_i,
  input wire logic [2:0] rd_size_i,
  input wire logic [3:0] rd_bit_i,
  output logic [31:0] rd_data_o,
  output logic rd_bit_o,
  // memory operand request
  input wire logic mem_req_i,
  input wire logic [2:0] mem_size_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  input wire logic mem_exc_stack_i,
  input wire logic mem_sp_auto_i,
  input wire logic [3:0] mem_bit_i,
  output logic mem_bit_o,
  // memory bus side
  output logic bus_req_o,
  output logic bus_word_o,
  output logic [15:0] bus_addr_o,
  output logic [15:0] bus_wdata_o,
  input wire logic [15:0] bus_rdata_i,
  output logic [15:0] bus_lane_data_o,
  output logic addr_err_o,
  // instruction byte stream
  input wire logic ib_valid_i,
  input wire logic [7:0] ib_byte_i,
  input wire logic ib_has_ext_i,
  output logic [7:0] dec_addr_field_o,
  output logic [7:0] dec_ext_o,
  output logic [7:0] dec_opcode_o,
  output logic dec_ea_start_o,
  output logic dec_done_o,
  // interrupts
  input wire logic [2:0] int_level_i,
  input wire logic int_req_i,
  input wire logic nmi_i,
  output logic int_accept_o,
  output logic [2:0] int_mask_o
);
  logic rst_s1;
  logic rst_n;
  opfmt_if rf();

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  opfmt_regbank u_bank
  (
    .clk(mclk_i),
    .rst_n(rst_n),
    .rf(rf)
  );

  function automatic logic is_word(input logic [2:0] sz);
    is_word = (sz == opfmt_pkg::SZ_WORD) || (sz == opfmt_pkg::SZ_LONG);
  endfunction

  // longword writes take two cycles: even register high half, then odd low half
  logic long_pend;
  logic next_long_pend;
  logic [15:0] long_lo;
  logic [15:0] next_long_lo;
  logic [2:0] long_reg;
  logic [2:0] next_long_reg;
  logic long_go;

  assign long_go = wr_valid_i && wr_size_i == opfmt_pkg::SZ_LONG;

  always_comb
  begin
    next_long_pend = long_go;
    next_long_lo = long_go ? wr_data_i[15:0] : long_lo;
    next_long_reg = long_go ? {wr_reg_i[2:1], 1'b1} : long_reg;
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      long_pend <= 1'b0;
      long_lo <= 16'h0000;
      long_reg <= 3'h0;
    end
    else
    begin
      long_pend <= next_long_pend;
      long_lo <= next_long_lo;
      long_reg <= next_long_reg;
    end
  end

  // one bank write port: a long's low half takes it in the following cycle
  always_comb
  begin
    rf.wr_idx = wr_reg_i;
    rf.wdata = wr_data_i[15:0];
    rf.we_hi = 1'b0;
    rf.we_lo = 1'b0;
    if (long_go)
    begin
      rf.wr_idx = {wr_reg_i[2:1], 1'b0};
      rf.wdata = wr_data_i[31:16];
      rf.we_hi = 1'b1;
      rf.we_lo = 1'b1;
    end
    else if (long_pend)
    begin
      rf.wr_idx = long_reg;
      rf.wdata = long_lo;
      rf.we_hi = 1'b1;
      rf.we_lo = 1'b1;
    end
    else if (wr_valid_i)
    begin
      rf.we_lo = 1'b1;
      rf.we_hi = (wr_size_i == opfmt_pkg::SZ_WORD);
    end
  end

  // register read formatting
  logic [2:0] rd_size_q;
  logic [3:0] rd_bit_q;
  always_comb
  begin
    rf.rd_a = (rd_size_i == opfmt_pkg::SZ_LONG) ? {rd_reg_i[2:1], 1'b0} : rd_reg_i;
    rf.rd_b = {rd_reg_i[2:1], 1'b1};
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_size_q <= opfmt_pkg::SZ_WORD;
      rd_bit_q <= 4'h0;
    end
    else
    begin
      rd_size_q <= rd_size_i;
      rd_bit_q <= rd_bit_i;
    end
  end

  always_comb
  begin
    case (rd_size_q)
      opfmt_pkg::SZ_LONG: rd_data_o = {rf.rdata_a, rf.rdata_b};
      opfmt_pkg::SZ_WORD: rd_data_o = {16'h0000, rf.rdata_a};
      opfmt_pkg::SZ_BCD: rd_data_o = {24'h000000, rf.rdata_a[7:4], rf.rdata_a[3:0]};
      default: rd_data_o = {24'h000000, rf.rdata_a[7:0]};
    endcase
    rd_bit_o = rf.rdata_a[rd_bit_q];
  end

  // memory side: alignment, big-endian lanes, forced word size
  logic force_word;
  logic want_word;
  logic misalign;
  always_comb
  begin
    force_word = mem_exc_stack_i || mem_sp_auto_i;
    want_word = is_word(mem_size_i) || force_word;
    misalign = mem_req_i && want_word && mem_addr_i[0];
  end

  logic bus_req;
  logic bus_word;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  logic addr_err;
  logic [3:0] mbit;
  logic mbyte;

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_req <= 1'b0;
      bus_word <= 1'b0;
      bus_addr <= 16'h0000;
      bus_wdata <= 16'h0000;
      addr_err <= 1'b0;
      mbit <= 4'h0;
      mbyte <= 1'b0;
    end
    else
    begin
      bus_req <= mem_req_i && !misalign;
      addr_err <= misalign;
      bus_word <= want_word;
      bus_addr <= mem_addr_i;
      // byte goes on the lane of its address, as the read side expects
      bus_wdata <= want_word ? mem_wdata_i : (mem_addr_i[0] ? {8'h00, mem_wdata_i[7:0]}
        : {mem_wdata_i[7:0], 8'h00});
      mbit <= mem_bit_i;
      mbyte <= !want_word;
    end
  end

  assign bus_req_o = bus_req;
  assign bus_word_o = bus_word;
  assign bus_addr_o = bus_addr;
  assign bus_wdata_o = bus_wdata;
  assign addr_err_o = addr_err;

  // bus lines carry byte n on [15:8] and n+1 on [7:0]
  always_comb
  begin
    if (mbyte)
    begin
      bus_lane_data_o = {8'h00, bus_addr[0] ? bus_rdata_i[7:0] : bus_rdata_i[15:8]};
      mem_bit_o = bus_lane_data_o[{1'b0, mbit[2:0]}];
    end
    else
    begin
      bus_lane_data_o = bus_rdata_i;
      mem_bit_o = bus_rdata_i[mbit];
    end
  end

  // decoder byte order: address field, optional extension, opcode
  opfmt_pkg::dec_state_e dstate;
  opfmt_pkg::dec_state_e next_dstate;
  logic [7:0] ea_f;
  logic [7:0] next_ea_f;
  logic [7:0] ext_f;
  logic [7:0] next_ext_f;
  logic [7:0] opc_f;
  logic [7:0] next_opc_f;
  logic has_ext;
  logic next_has_ext;
  logic ea_start;
  logic next_ea_start;
  logic done;
  logic next_done;

  always_comb
  begin
    next_dstate = dstate;
    next_ea_f = ea_f;
    next_ext_f = ext_f;
    next_opc_f = opc_f;
    next_has_ext = has_ext;
    next_ea_start = 1'b0;
    next_done = 1'b0;
    if (ib_valid_i)
    begin
      case (dstate)
        opfmt_pkg::DEC_ADDR:
        begin
          next_ea_f = ib_byte_i;
          next_has_ext = ib_has_ext_i;
          next_ext_f = 8'h00;
          next_ea_start = !ib_has_ext_i;
          next_dstate = ib_has_ext_i ? opfmt_pkg::DEC_EXT : opfmt_pkg::DEC_OPC;
        end
        opfmt_pkg::DEC_EXT:
        begin
          next_ext_f = ib_byte_i;
          next_ea_start = 1'b1;
          next_dstate = opfmt_pkg::DEC_OPC;
        end
        default:
        begin
          next_opc_f = ib_byte_i;
          next_done = 1'b1;
          next_dstate = opfmt_pkg::DEC_ADDR;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dstate <= opfmt_pkg::DEC_ADDR;
      ea_f <= 8'h00;
      ext_f <= 8'h00;
      opc_f <= 8'h00;
      has_ext <= 1'b0;
      ea_start <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      dstate <= next_dstate;
      ea_f <= next_ea_f;
      ext_f <= next_ext_f;
      opc_f <= next_opc_f;
      has_ext <= next_has_ext;
      ea_start <= next_ea_start;
      done <= next_done;
    end
  end

  assign dec_addr_field_o = ea_f;
  assign dec_ext_o = ext_f;
  assign dec_opcode_o = opc_f;
  assign dec_ea_start_o = ea_start;
  assign dec_done_o = done;

  // interrupt acceptance against the mask
  logic [2:0] mask;
  logic [2:0] next_mask;
  logic accept;
  logic next_accept;
  always_comb
  begin
    next_accept = nmi_i || (int_req_i && int_level_i > mask);
    next_mask = mask;
    if (nmi_i)
    begin
      next_mask = opfmt_pkg::MASK_RESET;
    end
    else if (next_accept)
    begin
      next_mask = int_level_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask <= opfmt_pkg::MASK_RESET;
      accept <= 1'b0;
    end
    else
    begin
      mask <= next_mask;
      accept <= next_accept;
    end
  end

  assign int_accept_o = accept;
  assign int_mask_o = mask;

  chk_odd_word_err: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mem_req_i && mem_addr_i[0] && (mem_sp_auto_i || mem_exc_stack_i) |=> addr_err && !bus_req)
    else $error("odd stack access not trapped");
  chk_err_blocks_bus: assert property (@(posedge mclk_i) disable iff (!rst_n)
    addr_err |-> !bus_req_o)
    else $error("faulting access reached the bus");
  chk_even_word_ok: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mem_req_i && !mem_addr_i[0] |=> bus_req_o && !addr_err_o)
    else $error("aligned access refused");
  chk_stack_word: assert property (@(posedge mclk_i) disable iff (!rst_n)
    mem_req_i && mem_exc_stack_i |=> bus_word_o)
    else $error("exception stack access not word");
  chk_nmi_taken: assert property (@(posedge mclk_i) disable iff (!rst_n)
    nmi_i |=> int_accept_o && int_mask_o == 3'h7)
    else $error("nmi not accepted");
  chk_mask_blocks: assert property (@(posedge mclk_i) disable iff (!rst_n)
    !nmi_i && int_req_i && int_level_i <= int_mask_o |=> !int_accept_o)
    else $error("masked interrupt accepted");
  chk_opc_after_ea: assert property (@(posedge mclk_i) disable iff (!rst_n)
    dec_done_o |-> $past(dstate) == opfmt_pkg::DEC_OPC)
    else $error("opcode taken before address field");
  chk_long_pair: assert property (@(posedge mclk_i) disable iff (!rst_n)
    long_go |=> long_pend && long_reg[0] ##1 !long_pend || long_go)
    else $error("longword low half not written");
endmodule
